// *** dv/cpbp_host.sv ***
// host cpu model driving the parallel port strobes and data bus
`timescale 1ns/1ps
module cpbp_host (
    input wire logic clk, // clock
    input wire cpbp_pkg::cpbp_data_t dout, // port drive value
    input wire logic oe_low, // port drives when low
    output logic chip_select_low, // chip select
    output logic write_strobe_low, // write strobe
    output logic read_strobe_low, // read strobe
    output cpbp_pkg::cpbp_sel_t sel, // register select
    output cpbp_pkg::cpbp_data_t bus // resolved bus level
);
    import cpbp_pkg::*;
    logic drv = 1'b0;
    cpbp_data_t wd;
    cpbp_data_t rel = 8'h00;
    initial {chip_select_low, write_strobe_low, read_strobe_low, sel, wd} = 15'h7000;
    // a released bus shows a changing pattern, so stale data never reads back
    assign bus = !oe_low ? dout : (drv ? wd : rel);
    always @(posedge clk) rel <= ~bus;
    // write: strobe low two cycles, data held one cycle past the rise
    task automatic write(input cpbp_sel_t a, input cpbp_data_t d, input logic cs);
        @(negedge clk);
        sel = a;
        wd = d;
        drv = 1'b1;
        chip_select_low = cs;
        write_strobe_low = 1'b0;
        repeat (2) @(negedge clk);
        write_strobe_low = 1'b1;
        @(negedge clk);
        drv = 1'b0;
        chip_select_low = 1'b1;
    endtask
    // read: data taken while the port drives, then the strobe rises
    task automatic read(input cpbp_sel_t a, input logic cs, output cpbp_data_t d,
                        output logic ok, output logic freed);
        ok = 1'b0;
        @(negedge clk);
        sel = a;
        chip_select_low = cs;
        @(negedge clk);
        read_strobe_low = 1'b0;
        for (int n = 0; n < 4 && !ok; n++) @(negedge clk) ok = (oe_low === 1'b0);
        @(negedge clk);
        d = bus;
        read_strobe_low = 1'b1;
        #1 freed = oe_low;
        @(negedge clk);
        chip_select_low = 1'b1;
    endtask
endmodule // cpbp_host

// *** dv/cpu_parallel_bus_port_tb_top.sv ***
// self-checking bench for the parallel host port
`timescale 1ns/1ps
module cpu_parallel_bus_port_tb_top;
    import cpbp_pkg::*;
    logic SYS_CLK;
    logic RST = 1'b1;
    logic chip_select_low, write_strobe_low, read_strobe_low, oe_low, wr_done, rd_start;
    logic ok, freed;
    cpbp_sel_t sel, wr_idx, rd_idx, mon_wi, mon_ri;
    cpbp_data_t bus, dout, wr_val, mon_wv, got;
    cpbp_data_t exp_regs [16];
    int failures = 0, check_count = 0, wd_cnt = 0, rs_cnt = 0, ow, orr;
    logic [7:0] lfsr = 8'h43;
    cpbp_top DUT (.SYS_CLK(SYS_CLK), .RST(RST), .CHIP_SELECT_LOW(chip_select_low),
        .WRITE_STROBE_LOW(write_strobe_low), .READ_STROBE_LOW(read_strobe_low),
        .REGISTER_SELECT_LINES(sel), .HOST_DATA_LINES_IN(bus), .HOST_DATA_LINES_OUT(dout),
        .HOST_DATA_LINES_OE_LOW(oe_low), .WRITE_DONE(wr_done), .WRITE_INDEX(wr_idx),
        .WRITE_VALUE(wr_val), .READ_START(rd_start), .READ_INDEX(rd_idx));
    cpbp_host host (.clk(SYS_CLK), .dout(dout), .oe_low(oe_low),
        .chip_select_low(chip_select_low), .write_strobe_low(write_strobe_low),
        .read_strobe_low(read_strobe_low), .sel(sel), .bus(bus));
    initial begin
        SYS_CLK = 1'b0;
        forever #20 SYS_CLK = ~SYS_CLK;
    end
    // pulses sampled mid-cycle, where registered outputs have settled
    always @(negedge SYS_CLK) begin
        if (wr_done === 1'b1) begin
            wd_cnt++;
            mon_wi = wr_idx;
            mon_wv = wr_val;
        end
        if (rd_start === 1'b1) begin
            rs_cnt++;
            mon_ri = rd_idx;
        end
    end
    function automatic logic [7:0] next_rand(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction
    task automatic results();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] e, input logic [7:0] s);
        check_count++;
        if (s !== e) begin
            $display("[FAIL] %s expected %h seen %h", what, e, s);
            failures++;
        end
    endtask
    // one-bit results kept apart so an unknown flag is never widened away
    task automatic chk_bit(input string what, input logic e, input logic s);
        check_count++;
        if (s !== e) begin
            $display("[FAIL] %s expected %b seen %b", what, e, s);
            failures++;
        end
    endtask
    // expected read value: last write to that entry, else the reset value
    function automatic cpbp_data_t expect_read(input cpbp_sel_t a);
        return exp_regs[a];
    endfunction
    // bounded wait for a pulse count to move
    task automatic wait_cnt(ref int cnt, input int old);
        for (int n = 0; n < 4 && cnt == old; n++) @(negedge SYS_CLK) #1;
        if (cnt == old) begin
            $display("[FAIL] pulse expected 1 seen 0");
            failures++;
            results();
        end
    endtask
    task automatic do_write(input cpbp_sel_t a, input cpbp_data_t d);
        int old;
        old = wd_cnt;
        host.write(a, d, 1'b0);
        wait_cnt(wd_cnt, old);
        exp_regs[a] = d;
        chk("write index", 8'(a), 8'(mon_wi));
        chk("write value", d, mon_wv);
    endtask
    task automatic do_read(input cpbp_sel_t a);
        int old;
        old = rs_cnt;
        host.read(a, 1'b0, got, ok, freed);
        wait_cnt(rs_cnt, old);
        chk_bit("bus driven", 1'b1, ok);
        chk("read data", expect_read(a), got);
        chk("read index", 8'(a), 8'(mon_ri));
        chk_bit("bus freed", 1'b1, freed);
    endtask
    // reset, every select code, random mix, deselected strobes, mid-run reset
    initial begin
        repeat (5) @(negedge SYS_CLK);
        RST = 1'b0;
        foreach (exp_regs[i]) exp_regs[i] = 8'h00;
        chk_bit("idle drive", 1'b1, oe_low);
        do_read(4'h5);
        for (int i = 0; i < 16; i++) begin
            lfsr = next_rand(lfsr);
            do_write(4'(i), lfsr);
        end
        for (int i = 0; i < 16; i++) do_read(4'(i));
        for (int i = 0; i < 24; i++) begin
            lfsr = next_rand(lfsr);
            if (lfsr[0]) do_write(lfsr[7:4], next_rand(lfsr));
            else do_read(lfsr[7:4]);
        end
        ow = wd_cnt;
        orr = rs_cnt;
        host.write(4'h2, ~exp_regs[2], 1'b1);
        host.read(4'h2, 1'b1, got, ok, freed);
        repeat (2) @(negedge SYS_CLK);
        chk_bit("deselected drive", 1'b0, ok);
        chk("deselected writes", 8'(ow), 8'(wd_cnt));
        chk("deselected reads", 8'(orr), 8'(rs_cnt));
        do_read(4'h2);
        RST = 1'b1;
        repeat (2) @(negedge SYS_CLK);
        RST = 1'b0;
        foreach (exp_regs[i]) exp_regs[i] = 8'h00;
        do_read(4'h9);
        results();
    end
endmodule // cpu_parallel_bus_port_tb_top

// *** hw/cpbp_edge.sv ***
// edge detector for one active-low host strobe
`timescale 1ns/1ps
`include "cpbp_params.svh"
module cpbp_edge (
    input wire logic clk, // system clock
    input wire logic rst, // synchronous reset, active high
    input wire logic line_low, // strobe, active low
    output logic fell, // one-cycle pulse on high to low
    output logic rose // one-cycle pulse on low to high
);
    import cpbp_pkg::*;

    cpbp_edge_s st;
    cpbp_edge_s next_st;

    // strobes idle high, so reset assumes high to avoid a false edge
    always_comb begin
        next_st = st;
        next_st.prev = line_low;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st.prev <= `CPBP_STROBE_IDLE;
        end else begin
            st <= next_st;
        end
    end

    // pulses come straight from the compare, no extra latency
    assign fell = st.prev & ~line_low;
    assign rose = ~st.prev & line_low;
endmodule // cpbp_edge

// *** hw/cpbp_params.svh ***
// constants for the parallel host port: widths, counts and reset values
`ifndef CPBP_PARAMS_SVH
`define CPBP_PARAMS_SVH
`define CPBP_DATA_W 8
`define CPBP_SEL_W 4
`define CPBP_NUM_REGS 16
`define CPBP_REG_RESET 8'h00
`define CPBP_STROBE_IDLE 1'b1
`endif

// *** hw/cpbp_pkg.sv ***
// types shared by the parallel host port modules
package cpbp_pkg;
    `include "cpbp_params.svh"

    typedef logic [`CPBP_DATA_W-1:0] cpbp_data_t;
    typedef logic [`CPBP_SEL_W-1:0] cpbp_sel_t;

    // bus phase of the host port
    typedef enum logic [1:0] {
        PH_IDLE  = 2'b00,
        PH_WRITE = 2'b01,
        PH_READ  = 2'b10
    } cpbp_phase_e;

    // state of the host port, apart from the strobe edge detectors
    typedef struct packed {
        cpbp_phase_e phase;
        cpbp_data_t [`CPBP_NUM_REGS-1:0] regs;
        cpbp_sel_t wr_addr;
        cpbp_data_t wr_data;
        cpbp_data_t dout;
        logic wr_done;
        logic rd_start;
        cpbp_sel_t rd_index;
    } cpbp_state_s;

    // state of one strobe edge detector
    typedef struct packed {
        logic prev;
    } cpbp_edge_s;
endpackage

// *** hw/cpbp_top.sv ***
// parallel host port: strobe-timed 8-bit access to 16 internal registers
//
// Summary of operation
// [RULE1] eight bidirectional data lines, bit 0 least significant
// [RULE2] chip select low enables strobe-controlled transfers
// [RULE3] chip select high keeps data lines released
// [RULE4] write value loaded at write strobe rising edge
// [RULE5] read drives selected register from strobe fall
// [RULE6] four select lines choose the accessed register
// [RULE7] reset clears registers, returns port to idle
// [RULE8] data lines released once read strobe rises
`timescale 1ns/1ps
`include "cpbp_params.svh"
module cpbp_top (
    input wire logic SYS_CLK, // 25 MHz system clock
    input wire logic RST, // synchronous reset, active high
    input wire logic CHIP_SELECT_LOW, // chip select, active low
    input wire logic WRITE_STROBE_LOW, // write strobe, active low
    input wire logic READ_STROBE_LOW, // read strobe, active low
    input wire cpbp_pkg::cpbp_sel_t REGISTER_SELECT_LINES, // register select
    input wire cpbp_pkg::cpbp_data_t HOST_DATA_LINES_IN, // data bus level seen
    output cpbp_pkg::cpbp_data_t HOST_DATA_LINES_OUT, // data bus drive value
    output logic HOST_DATA_LINES_OE_LOW, // low while port drives the bus
    output logic WRITE_DONE, // pulse: a register was written
    output cpbp_pkg::cpbp_sel_t WRITE_INDEX, // index of last write
    output cpbp_pkg::cpbp_data_t WRITE_VALUE, // value of last write
    output logic READ_START, // pulse: a read cycle began
    output cpbp_pkg::cpbp_sel_t READ_INDEX // index of last read
);
    import cpbp_pkg::*;

    cpbp_state_s st;
    cpbp_state_s next_st;
    logic wr_fell;
    logic wr_rose;
    logic rd_fell;
    logic rd_rose;
    logic selected;
    logic commit;
    logic [`CPBP_NUM_REGS-1:0] entry_we;

    // strobe edges; inputs are already synchronous to SYS_CLK
    cpbp_edge u_wr_edge (
        .clk(SYS_CLK),
        .rst(RST),
        .line_low(WRITE_STROBE_LOW),
        .fell(wr_fell),
        .rose(wr_rose)
    );

    cpbp_edge u_rd_edge (
        .clk(SYS_CLK),
        .rst(RST),
        .line_low(READ_STROBE_LOW),
        .fell(rd_fell),
        .rose(rd_rose)
    );

    assign selected = ~CHIP_SELECT_LOW; // see [RULE2]

    // a write lands only on the strobe's rising edge after capture
    assign commit = (st.phase == PH_WRITE) && wr_rose; // see [RULE4]

    // one write enable per register entry, decoded from the captured select
    genvar g;
    generate
        for (g = 0; g < `CPBP_NUM_REGS; g = g + 1) begin : g_we
            assign entry_we[g] = commit && (st.wr_addr == `CPBP_SEL_W'(g)); // see [RULE6]
        end
    endgenerate

    // next state of the bus phase machine and register image
    always_comb begin
        next_st = st;
        next_st.wr_done = 1'b0;
        next_st.rd_start = 1'b0;
        for (int i = 0; i < `CPBP_NUM_REGS; i++) begin
            if (entry_we[i]) begin
                next_st.regs[i] = st.wr_data; // see [RULE4]
            end
        end
        case (st.phase)
            PH_IDLE: begin
                if (selected && !WRITE_STROBE_LOW) begin
                    // capture every cycle; the last value before the rise wins
                    next_st.wr_addr = REGISTER_SELECT_LINES; // see [RULE6]
                    next_st.wr_data = HOST_DATA_LINES_IN; // see [RULE1]
                    next_st.phase = PH_WRITE;
                end else if (selected && rd_fell) begin
                    // contents frozen at read start so the bus stays stable
                    next_st.dout = st.regs[REGISTER_SELECT_LINES]; // see [RULE5]
                    next_st.rd_index = REGISTER_SELECT_LINES;
                    next_st.rd_start = 1'b1;
                    next_st.phase = PH_READ;
                end
            end
            PH_WRITE: begin
                if (selected && !WRITE_STROBE_LOW) begin
                    next_st.wr_addr = REGISTER_SELECT_LINES; // see [RULE6]
                    next_st.wr_data = HOST_DATA_LINES_IN;
                end
                if (wr_rose) begin
                    next_st.wr_done = 1'b1; // see [RULE4]
                    next_st.phase = PH_IDLE;
                end
            end
            PH_READ: begin
                // leaving on either release keeps the bus from hanging driven
                if (READ_STROBE_LOW || CHIP_SELECT_LOW) begin
                    next_st.phase = PH_IDLE; // see [RULE8]
                end
            end
            default: begin
                next_st.phase = PH_IDLE;
            end
        endcase
    end

    // state register; reset clears the whole image and the phase
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            st <= '0; // see [RULE7]
        end else begin
            st <= next_st;
        end
    end

    // drive only during a live read; chip select high floats the bus at once
    assign HOST_DATA_LINES_OE_LOW = ~((st.phase == PH_READ) && selected
                                      && !READ_STROBE_LOW); // see [RULE3] [RULE8]
    assign HOST_DATA_LINES_OUT = st.dout; // see [RULE5]
    assign WRITE_DONE = st.wr_done;
    assign WRITE_INDEX = st.wr_addr;
    assign WRITE_VALUE = st.wr_data;
    assign READ_START = st.rd_start;
    assign READ_INDEX = st.rd_index;

    // checks on the port's behaviour
    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (RST);

    // released whenever chip select is high
    cs_high_float_a: assert property ( // see [RULE3]
        CHIP_SELECT_LOW |-> HOST_DATA_LINES_OE_LOW
    ) else $error("bus driven while chip select high");

    // released whenever the read strobe is high
    read_release_a: assert property ( // see [RULE8]
        READ_STROBE_LOW |-> HOST_DATA_LINES_OE_LOW
    ) else $error("bus driven while read strobe high");

    // read start drives the bus on the next cycle while the read holds
    read_drive_a: assert property ( // see [RULE5]
        (st.phase == PH_IDLE && selected && rd_fell && WRITE_STROBE_LOW)
        ##1 (selected && !READ_STROBE_LOW) |-> !HOST_DATA_LINES_OE_LOW
    ) else $error("read cycle did not drive the bus");

    // read data is the register picked by the select lines
    read_data_a: assert property ( // see [RULE6]
        (st.phase == PH_IDLE && selected && rd_fell && WRITE_STROBE_LOW)
        |=> READ_START && HOST_DATA_LINES_OUT == $past(st.regs[REGISTER_SELECT_LINES])
    ) else $error("read data not from selected register");

    // captured value lands in the captured entry at the strobe rise
    write_commit_a: assert property ( // see [RULE4]
        commit |=> st.regs[$past(st.wr_addr)] == $past(st.wr_data)
    ) else $error("write value not stored");

    // completion pulse is exactly one cycle after the rise
    write_done_a: assert property ( // see [RULE4]
        commit |=> WRITE_DONE ##1 !WRITE_DONE
    ) else $error("write completion pulse wrong");

    // no write without a selected write phase before it
    write_needs_cs_a: assert property ( // see [RULE2]
        WRITE_DONE |-> $past(st.phase) == PH_WRITE && $past(wr_rose)
    ) else $error("write without selected strobe");

    // reset leaves the port idle and the image cleared
    reset_clear_a: assert property ( // see [RULE7]
        @(posedge SYS_CLK) disable iff (1'b0)
        RST |=> st.regs == '0 && st.phase == PH_IDLE && HOST_DATA_LINES_OE_LOW
    ) else $error("reset did not clear port");

    // a selected strobe fall captures the select code and the data lines
    write_capture_a: assert property ( // see [RULE6]
        st.phase == PH_IDLE && selected && wr_fell
        |=> st.phase == PH_WRITE && WRITE_INDEX == $past(REGISTER_SELECT_LINES)
            && WRITE_VALUE == $past(HOST_DATA_LINES_IN)
    ) else $error("write capture missed select or data");

    // between captures the reported write index and value stand still
    write_index_hold_a: assert property ( // see [RULE6]
        st.phase == PH_IDLE && !(selected && !WRITE_STROBE_LOW)
        |=> $stable(WRITE_INDEX) && $stable(WRITE_VALUE)
    ) else $error("write index moved without a capture");

    // the image only changes through a committed write
    regs_stable_a: assert property ( // see [RULE4]
        !commit |=> $stable(st.regs)
    ) else $error("register image changed without a write");

    // an idle port never reports a finished write
    idle_no_write_a: assert property ( // see [RULE4]
        st.phase == PH_IDLE |=> !WRITE_DONE
    ) else $error("write finished from idle");

    // a deselected idle port neither starts a read nor captures a write
    deselect_ignore_a: assert property ( // see [RULE2]
        st.phase == PH_IDLE && CHIP_SELECT_LOW |=> st.phase == PH_IDLE && !READ_START
    ) else $error("deselected strobe started a transfer");

    // read start reports the select code seen at the strobe fall
    read_index_a: assert property ( // see [RULE6]
        READ_START |-> st.phase == PH_READ && READ_INDEX == $past(REGISTER_SELECT_LINES)
    ) else $error("read index not the selected code");

    // data frozen at read start stays put while the read is live
    read_hold_a: assert property ( // see [RULE5]
        st.phase == PH_READ && selected && !READ_STROBE_LOW |=> $stable(HOST_DATA_LINES_OUT)
    ) else $error("read data moved during the read");

    // the read phase ends at the edge that sees the strobe rise
    read_end_a: assert property ( // see [RULE8]
        st.phase == PH_READ && rd_rose |=> st.phase == PH_IDLE && HOST_DATA_LINES_OE_LOW
    ) else $error("read phase outlived its strobe");
endmodule // cpbp_top
